// >>> hdl/reset_and_clock_source_control.v
// reset stretching, strap capture and pll reference selection
`timescale 1ns/1ps
`include "rst_clk_defines.vh"

module reset_and_clock_source_control #(
  parameter RESET_HOLD_CYCLES = `RESET_HOLD_CYCLES
) (
  input  wire REF_CLK,                // processor clock, 125 MHz
  input  wire RST,                    // synchronous reset, active high
  input  wire EXTERNAL_RESET_N,       // external reset pin, active low
  input  wire WATCHDOG_EVENT,         // watchdog event, same clock
  input  wire REF_STRAP_IN,           // clock reference strap level
  input  wire I2C_ROLE_STRAP_IN,      // i2c role strap level
  input  wire REF_SELECT_WRITE,       // strobe to change reference
  input  wire REF_SELECT_DATA,        // new reference, 1 = bit clock
  input  wire OSC_PRESENT,            // crystal oscillator fitted
  input  wire SERIAL_PORT_MASTER,     // serial audio port is master
  output reg  INTERNAL_RESET,         // whole-device reset, active high
  output reg  WATCHDOG_RESET_ACTIVE,  // reset caused by watchdog
  output reg  STRAP_OUT_EN,           // strap pins driven (low until straps sampled)
  output reg  STRAP_PULL_EN,          // strap internal pulls enabled
  output reg  REF_SELECT,             // pll reference, 1 = bit clock
  output reg  I2C_ROLE_SLAVE,         // 1 = i2c slave, 0 = master
  output reg  CODEC_CLK_FROM_PLL,     // codec clocked from pll
  output reg  SERIAL_CLK_FROM_PLL,    // serial port clock from pll
  output reg  STRAPS_VALID            // straps captured
);

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change accepted when 2 and 3 agree
  reg  [2:0] ext_sync;
  reg  [2:0] ref_sync;
  reg  [2:0] role_sync;
  reg        ext_n;
  reg        ref_lvl;
  reg        role_lvl;

  always @(posedge REF_CLK) begin
    if (RST) begin
      ext_sync  <= 3'h0;
      ref_sync  <= 3'h7;
      role_sync <= 3'h7;
      ext_n     <= 1'h0;
      ref_lvl   <= 1'h1;
      role_lvl  <= 1'h1;
    end else begin
      ext_sync  <= {ext_sync[1:0], EXTERNAL_RESET_N};
      ref_sync  <= {ref_sync[1:0], REF_STRAP_IN};
      role_sync <= {role_sync[1:0], I2C_ROLE_STRAP_IN};
      if (ext_sync[1] == ext_sync[2])
        ext_n <= ext_sync[2];
      if (ref_sync[1] == ref_sync[2])
        ref_lvl <= ref_sync[2];
      if (role_sync[1] == role_sync[2])
        role_lvl <= role_sync[2];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // reset sequencer
  // both sources land in this one state machine, so the device has a
  // single reset domain and release happens on one REF_CLK edge
  reg [1:0]  state;
  reg [21:0] hold_count;
  reg        power_up;
  reg        next_internal_reset;

  always @(posedge REF_CLK) begin
    if (RST) begin
      state      <= `ST_RESET;
      hold_count <= 22'h0;
      power_up   <= 1'h1;
    end else if (!ext_n) begin
      state      <= `ST_RESET;
      hold_count <= 22'h0;
      power_up   <= 1'h1;
    end else if (WATCHDOG_EVENT && state == `ST_RUN) begin
      state      <= `ST_STRETCH;
      hold_count <= 22'h0;
      power_up   <= 1'h0;
    end else begin
      case (state)
        `ST_RESET: begin
          state      <= `ST_STRETCH;
          hold_count <= 22'h0;
        end
        `ST_STRETCH: begin
          // counted from pin release or watchdog event; stretch >= RESET_HOLD_CYCLES cycles, 3 ms by default
          if ({10'h0, hold_count} >= RESET_HOLD_CYCLES - 1)
            state <= power_up ? `ST_SAMPLE : `ST_RUN;
          else
            hold_count <= hold_count + 22'h1;
        end
        `ST_SAMPLE: begin
          state    <= `ST_RUN;
          power_up <= 1'h0;
        end
        `ST_RUN:  state <= `ST_RUN;
        default:  state <= `ST_RESET;
      endcase
    end
  end

  always @* begin
    next_internal_reset = (state != `ST_RUN);
  end

  ////////////////////////////////////////////////////////////////////
  // strap capture
  // the captured levels are kept apart from the live pin levels: once
  // the device drives the strap pins again they no longer show the
  // board straps, so a later watchdog reset must not look at the pins
  // and restores from these copies instead
  reg        strap_ref;
  reg        strap_role;

  always @(posedge REF_CLK) begin
    if (RST) begin
      strap_ref  <= `SEL_BIT_CLOCK;
      strap_role <= `I2C_SLAVE;
    end else if (state == `ST_SAMPLE) begin
      strap_ref  <= ref_lvl ? `SEL_BIT_CLOCK : `SEL_CRYSTAL;
      strap_role <= role_lvl ? `I2C_SLAVE : `I2C_MASTER;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // next values of the outputs
  reg        next_ref_select;
  reg        next_role_slave;
  reg        next_straps_valid;
  reg        next_watchdog_active;
  reg        next_strap_out_en;
  reg        next_strap_pull_en;
  reg        next_codec_clk;
  reg        next_serial_clk;

  always @* begin
    next_ref_select   = REF_SELECT;
    next_role_slave   = I2C_ROLE_SLAVE;
    next_straps_valid = STRAPS_VALID;
    if (state == `ST_SAMPLE) begin
      next_ref_select   = ref_lvl ? `SEL_BIT_CLOCK : `SEL_CRYSTAL;
      next_role_slave   = role_lvl ? `I2C_SLAVE : `I2C_MASTER;
      next_straps_valid = 1'h1;
    end else if (power_up) begin
      next_straps_valid = 1'h0;
    end else if (state == `ST_RUN && REF_SELECT_WRITE) begin
      next_ref_select   = REF_SELECT_DATA;
    end else if (next_internal_reset) begin
      // watchdog reset returns the software choice to the strap value
      next_ref_select   = strap_ref;
      next_role_slave   = strap_role;
    end
  end

  always @* begin
    next_watchdog_active = next_internal_reset && !power_up;
    // straps stay high-z with pulls on until they are sampled
    next_strap_out_en    = !power_up;
    next_strap_pull_en   = power_up;
    // the pll always clocks the processor; codec only without crystal
    next_codec_clk       = !OSC_PRESENT;
    next_serial_clk      = SERIAL_PORT_MASTER;
  end

  ////////////////////////////////////////////////////////////////////
  // outputs, all registered
  always @(posedge REF_CLK) begin
    if (RST) begin
      INTERNAL_RESET        <= 1'h1;
      WATCHDOG_RESET_ACTIVE <= 1'h0;
      STRAP_OUT_EN          <= 1'h0;
      STRAP_PULL_EN         <= 1'h1;
      REF_SELECT            <= `SEL_BIT_CLOCK;
      I2C_ROLE_SLAVE        <= `I2C_SLAVE;
      CODEC_CLK_FROM_PLL    <= 1'h0;
      SERIAL_CLK_FROM_PLL   <= 1'h0;
      STRAPS_VALID          <= 1'h0;
    end else begin
      INTERNAL_RESET        <= next_internal_reset;
      WATCHDOG_RESET_ACTIVE <= next_watchdog_active;
      STRAP_OUT_EN          <= next_strap_out_en;
      STRAP_PULL_EN         <= next_strap_pull_en;
      REF_SELECT            <= next_ref_select;
      I2C_ROLE_SLAVE        <= next_role_slave;
      CODEC_CLK_FROM_PLL    <= next_codec_clk;
      SERIAL_CLK_FROM_PLL   <= next_serial_clk;
      STRAPS_VALID          <= next_straps_valid;
    end
  end

  // REF_SELECT picks the pll reference; the mux itself is analog
  // limitation: pll floor of `MIN_REF_HZ is not checked here
  // a reference below that floor goes unnoticed, so the board must keep
  // the bit clock running before the strap is sampled
  // the stretch counter is sized for the 125 MHz default; a much
  // longer hold count needs a wider counter

endmodule

// >>> hdl/rst_clk_defines.vh
// constants for the reset and clock-source control block
`ifndef RST_CLK_DEFINES_VH
`define RST_CLK_DEFINES_VH
`define RESET_HOLD_NS      3000000
`define CLK_PERIOD_NS      8
`define RESET_HOLD_CYCLES  ((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_REF_HZ         44000
`define ST_RESET           2'h0
`define ST_STRETCH         2'h1
`define ST_SAMPLE          2'h2
`define ST_RUN             2'h3
`define SEL_BIT_CLOCK      1'h1
`define SEL_CRYSTAL        1'h0
`define I2C_SLAVE          1'h1
`define I2C_MASTER         1'h0
`endif

// >>> test/rst_clk_monitor.sv
// checker for the reset and clock-source block
`timescale 1ns/1ps
module rst_clk_monitor #(parameter RESET_HOLD_CYCLES = 20) (
  input wire REF_CLK, RST, EXTERNAL_RESET_N, WATCHDOG_EVENT,
  input wire REF_SELECT_WRITE, REF_SELECT_DATA, OSC_PRESENT,
  input wire SERIAL_PORT_MASTER, INTERNAL_RESET, STRAP_OUT_EN,
  input wire STRAP_PULL_EN, REF_SELECT, I2C_ROLE_SLAVE, STRAPS_VALID,
  input wire CODEC_CLK_FROM_PLL, SERIAL_CLK_FROM_PLL);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  reg [31:0] held = 32'h0;
  always @(posedge REF_CLK) held <= INTERNAL_RESET ? held + 32'h1 : 32'h0;
  a_codec_clock: assert property (##1
    CODEC_CLK_FROM_PLL == !$past(OSC_PRESENT)) else $error("codec");
  a_port_clock: assert property (##1
    SERIAL_CLK_FROM_PLL == $past(SERIAL_PORT_MASTER)) else $error("port");
  a_straps_released: assert property (!STRAPS_VALID |->
    !STRAP_OUT_EN && STRAP_PULL_EN) else $error("straps");
  a_pin_reset: assert property ($fell(EXTERNAL_RESET_N) |->
    ##[1:8] INTERNAL_RESET) else $error("pin");
  a_stretch_min: assert property ($fell(INTERNAL_RESET) |->
    held >= RESET_HOLD_CYCLES) else $error("short");
  a_dog_reset: assert property (!INTERNAL_RESET && WATCHDOG_EVENT |->
    ##[1:2] INTERNAL_RESET) else $error("dog");
  a_select_write: assert property (!INTERNAL_RESET &&
    REF_SELECT_WRITE && !WATCHDOG_EVENT |=>
    REF_SELECT == $past(REF_SELECT_DATA)) else $error("write");
  a_role_kept: assert property (STRAPS_VALID && $past(STRAPS_VALID)
    |-> $stable(I2C_ROLE_SLAVE)) else $error("role");
  c_power: cover property ($fell(STRAPS_VALID));
  c_dog: cover property (WATCHDOG_EVENT && !INTERNAL_RESET);
  c_write: cover property (REF_SELECT_WRITE && !INTERNAL_RESET);
endmodule
bind reset_and_clock_source_control rst_clk_monitor
  #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) i_mon (.*);

// >>> test/strap_pin_model.sv
// far side: reset pin source and strap resistors
`timescale 1ns/1ps
module strap_pin_model (
  input  wire clk, hold,           // clock, reset pin held low
  input  wire rpd, qpd, oe, pe,    // pull-downs, device drive, pulls
  output reg  en = 1'h0,           // reset pin
  output reg  rp = 1'h1, qp = 1'h1 // strap levels
);
  reg t = 1'h0;
  // a pin nobody drives or pulls wanders instead of keeping a level
  always @(posedge clk) begin
    t <= ~t;
    en <= ~hold;
    rp <= oe || !pe ? t : !rpd;
    qp <= oe || !pe ? t : !qpd;
  end
endmodule

// >>> test/reset_and_clock_source_control_tb_top.sv
// bench for the reset and clock-source block
`timescale 1ns/1ps
module reset_and_clock_source_control_tb_top;
  localparam HOLD = 20;
  reg c = 1'h0, rst = 1'h1, hold = 1'h1, rpd = 1'h0, qpd = 1'h0, wd = 1'h0;
  reg wr = 1'h0, wv = 1'h0, osc = 1'h1, sm = 1'h0;
  wire en, rp, qp, ir, wa, oe, pe, rs, sl, cp, sp, sv;
  integer miscompares = 0, samples_checked = 0, cyc = 0, n;
  always #4 c = ~c;
  strap_pin_model i_pins (.clk(c), .hold(hold), .rpd(rpd), .qpd(qpd),
    .oe(oe), .pe(pe), .en(en), .rp(rp), .qp(qp));
  reset_and_clock_source_control #(.RESET_HOLD_CYCLES(HOLD)) i_dut (
    .REF_CLK(c), .RST(rst), .EXTERNAL_RESET_N(en), .WATCHDOG_EVENT(wd),
    .REF_STRAP_IN(rp), .I2C_ROLE_STRAP_IN(qp), .REF_SELECT_WRITE(wr),
    .REF_SELECT_DATA(wv), .OSC_PRESENT(osc), .SERIAL_PORT_MASTER(sm),
    .INTERNAL_RESET(ir), .WATCHDOG_RESET_ACTIVE(wa), .STRAP_OUT_EN(oe),
    .STRAP_PULL_EN(pe), .REF_SELECT(rs), .I2C_ROLE_SLAVE(sl),
    .CODEC_CLK_FROM_PLL(cp), .SERIAL_CLK_FROM_PLL(sp), .STRAPS_VALID(sv));
  task chk(input logic s, input logic e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %0t seen %b expected %b", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge c) if (++cyc == 2000) begin miscompares++; wrap_up; end
  task go(input integer k); repeat (k) @(posedge c); #1; endtask
  task run_wait; n = 0;
    while (ir !== 1'h0 && n < 99) begin go(1); n++; end
  endtask
  // the write lands while reset still stands, so it must be dropped
  task t_power(input logic a, input logic b);
    @(posedge c); hold <= 1'h1; rpd <= a; qpd <= b;
    go(9); chk(ir, 1'h1); chk(oe, 1'h0); chk(pe, 1'h1);
    chk(wa, 1'h0);
    @(posedge c); hold <= 1'h0; wr <= 1'h1; wv <= a;
    @(posedge c); wr <= 1'h0;
    run_wait; chk(n >= HOLD, 1'h1);
    chk(rs, !a); chk(sl, !b); chk(sv, 1'h1);
  endtask
  task t_write(input logic d);
    @(posedge c); wr <= 1'h1; wv <= d;
    @(posedge c); wr <= 1'h0;
    go(1); chk(rs, d);
  endtask
  task t_dog;
    t_write(1'h0);
    @(posedge c); wd <= 1'h1;
    @(posedge c); wd <= 1'h0;
    go(1); chk(ir, 1'h1); chk(wa, 1'h1);
    run_wait; chk(n >= HOLD, 1'h1);
    chk(rs, 1'h1); chk(sl, 1'h1); chk(oe, 1'h1);
    chk(wa, 1'h0);
  endtask
  task t_clk(input logic o, input logic m);
    @(posedge c); osc <= o; sm <= m;
    go(2); chk(cp, !o); chk(sp, m);
  endtask
  initial begin
    repeat (4) @(posedge c);
    rst <= 1'h0;
    t_power(1'h0, 1'h0); t_write(1'h0); t_write(1'h1); t_dog;
    t_clk(1'h0, 1'h1); t_clk(1'h1, 1'h0); t_power(1'h1, 1'h1);
    wrap_up;
  end
endmodule
